// >>> testbench/tb.sv
`timescale 1ns/1ns
module tb import ssf_pkg::*; ();
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        clk_sys      = 1'b0;
   logic        srst         = 1'b1;
   logic        psel         = 1'b0;
   logic        penable      = 1'b0;
   logic        pwrite       = 1'b0;
   logic [7:0]  paddr        = 8'h00;
   logic [31:0] pwdata       = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [1:0]  cur_state    = 2'h0;
   logic        gf_valid     = 1'b0;
   logic        gf_low_el    = 1'b0;
   logic [62:0] gf_ipa       = 63'h0;
   logic        gf_ns_space  = 1'b0;
   logic [1:0]  ext_dbg_bits = 2'h0;
   logic        tb_enabled   = 1'b0;
   logic        tb_acc_req   = 1'b0;
   logic        lor_acc_req  = 1'b0;
   logic        lor_hit      = 1'b0;
   logic        lor_pa_ns    = 1'b0;
   logic        route_to_hyp;
   logic [1:0]  fault_space;
   logic        tb_prohibit;
   logic        tb_trap;
   logic        lor_access_ok;
   logic        lor_region_apply;
   logic [31:0] rdat;
   logic        rerr;
   int          miscompares  = 0;
   int          tests_run    = 0;

   ssf_top ssf_top_i (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .cur_state(cur_state), .gf_valid(gf_valid), .gf_low_el(gf_low_el), .gf_ipa(gf_ipa),
      .gf_ns_space(gf_ns_space), .ext_dbg_bits(ext_dbg_bits), .tb_enabled(tb_enabled),
      .tb_acc_req(tb_acc_req), .lor_acc_req(lor_acc_req), .lor_hit(lor_hit), .lor_pa_ns(lor_pa_ns),
      .route_to_hyp(route_to_hyp), .fault_space(fault_space), .tb_prohibit(tb_prohibit),
      .tb_trap(tb_trap), .lor_access_ok(lor_access_ok), .lor_region_apply(lor_region_apply));

   always #25 clk_sys = ~clk_sys;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         miscompares++;
         finish_test();
      end
   endtask : apb

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] msk, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0000_0000);
      chk(rdat & msk, exp);
      chk(rerr, 1'b0);
   endtask : rd_chk

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_ids();
      rd_chk(OFF_PFR0_HI, 32'h00f0_0000, 32'h0010_0000);
      rd_chk(OFF_PFR1_LO, 32'hf000_0000, 32'h1000_0000);
      rd_chk(OFF_HCFG_HI, 32'h0001_0000, 32'h0000_0000);
      rd_chk(OFF_HFA_HI, 32'hffff_ffff, 32'h0000_0000);
      apb(1'b1, OFF_DCS_LO, 32'hffff_ffff);
      rd_chk(OFF_DCS_LO, 32'hffff_ffff, 32'h0000_0000);
      apb(1'b0, 8'h44, 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
      chk(rerr, 1'b1);
      apb(1'b1, 8'h02, 32'hffff_ffff);
      chk(rerr, 1'b1);
   endtask : t_ids

   task automatic t_rng();
      for (int t = 0; t < 2; t++) begin
         apb(1'b1, OFF_MSC, 32'(t) << MSC_RANDOM_TRAP_BIT_BIT);
         rd_chk(OFF_ISA_HI, 32'hf000_0000, 32'(t) << 28);
      end
   endtask : t_rng

   task automatic t_fault(input logic rb, input logic [1:0] st);
      apb(1'b1, OFF_HCFG_HI, {15'h0, rb, 16'h0000});
      @(posedge clk_sys);
      cur_state <= st;
      gf_valid  <= 1'b1;
      gf_low_el <= 1'b1;
      gf_ipa    <= {31'h1234_5678, st, 30'h2bcd_ef01};
      gf_ns_space <= 1'b1;
      @(posedge clk_sys);
      gf_valid <= 1'b0;
      #1;
      chk(route_to_hyp, rb);
      if (rb) begin
         chk(fault_space, (st == 2'h0) ? 2'h1 : st);
         rd_chk(OFF_HFA_HI, 32'hffff_ffff, {(st == 2'h0), 31'h1234_5678});
         rd_chk(OFF_HFA_LO, 32'hffff_ffff, {st, 30'h2bcd_ef01});
      end
      rd_chk(OFF_ISTAT, 32'h0000_0001, {31'h0, rb});
      chk(irq, 1'b0);
      apb(1'b1, OFF_IMASK, 32'h0000_0007);
      #1;
      chk(irq, rb);
      apb(1'b1, OFF_ISTAT, 32'h0000_0001);
      #1;
      chk(irq, 1'b0);
      apb(1'b1, OFF_IMASK, 32'h0000_0000);
   endtask : t_fault

   task automatic t_lor(input logic nsb);
      apb(1'b1, OFF_MSC, {31'h0, nsb});
      @(posedge clk_sys);
      lor_acc_req <= 1'b1;
      lor_hit     <= 1'b1;
      lor_pa_ns   <= nsb;
      @(posedge clk_sys);
      lor_acc_req <= 1'b0;
      #1;
      chk(lor_access_ok, nsb);
      chk(lor_region_apply, nsb);
      rd_chk(OFF_ISTAT, 32'h0000_0004, {29'h0, ~nsb, 2'h0});
      apb(1'b1, OFF_ISTAT, 32'h0000_0004);
   endtask : t_lor

   task automatic t_dbg();
      for (int v = 0; v < 4; v++) begin
         @(posedge clk_sys);
         ext_dbg_bits <= 2'(v);
         rd_chk(OFF_DCS_LO, 32'h6000_0000, 32'(v) << DCS_MIR_LSB);
      end
   endtask : t_dbg

   // Reserved owner codes are expected to behave as a secure owner
   task automatic t_trace();
      logic [1:0] own;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, OFF_MDC_LO, 32'(c) << MDC_SEL_LSB);
         own = c[1] ? (c[2] ? 2'h2 : 2'h1) : 2'h0;
         for (int st = 0; st < 4; st++) begin
            @(posedge clk_sys);
            cur_state  <= 2'(st);
            tb_enabled <= (st != 3);
            tb_acc_req <= 1'b1;
            @(posedge clk_sys);
            tb_acc_req <= 1'b0;
            #1;
            chk(tb_trap, !c[0] || own != 2'(st));
            chk(tb_prohibit, st != 3 && own != 2'(st));
         end
      end
   endtask : t_trace

   initial begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      t_ids();
      t_rng();
      t_fault(1'b1, 2'h2);
      t_fault(1'b1, 2'h1);
      t_fault(1'b0, 2'h2);
      t_fault(1'b1, 2'h0);
      t_lor(1'b0);
      t_lor(1'b1);
      t_dbg();
      t_trace();
      finish_test();
   end
endmodule : tb

// >>> verilog/ssf_pkg.sv
// Functional notes
// (RULE_01) Random field reads one with generator or trap
// (RULE_02) Monitor sets trap bit once, early
// (RULE_03) Four-world version field in bits 55:52
// (RULE_04) Trap support field in bits 31:28
// (RULE_05) Route bit sends low-level granule faults up
// (RULE_06) Route bit zero without four-world support
// (RULE_07) Fault address bit 63 gives address space
// (RULE_08) Realm hypervisor faults: space bit zero
// (RULE_09) Non-secure hypervisor faults: space bit zero
// (RULE_10) Ordering-region access only with non-secure bit
// (RULE_11) Ordering regions only in non-secure space
// (RULE_12) Debug status bits 30:29 mirrored
// (RULE_13) Extension bit and select choose trace owner
// (RULE_14) Low select bit chooses trap scope
// (RULE_15) Ext one with select 0x reserved
package ssf_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] OFF_ISA_LO    = 8'h00;
   localparam logic [7:0] OFF_ISA_HI    = 8'h04;
   localparam logic [7:0] OFF_PFR0_LO   = 8'h08;
   localparam logic [7:0] OFF_PFR0_HI   = 8'h0c;
   localparam logic [7:0] OFF_PFR1_LO   = 8'h10;
   localparam logic [7:0] OFF_PFR1_HI   = 8'h14;
   localparam logic [7:0] OFF_HCFG_LO   = 8'h18;
   localparam logic [7:0] OFF_HCFG_HI   = 8'h1c;
   localparam logic [7:0] OFF_HFA_LO    = 8'h20;
   localparam logic [7:0] OFF_HFA_HI    = 8'h24;
   localparam logic [7:0] OFF_DCS_LO    = 8'h28;
   localparam logic [7:0] OFF_DCS_HI    = 8'h2c;
   localparam logic [7:0] OFF_MDC_LO    = 8'h30;
   localparam logic [7:0] OFF_MDC_HI    = 8'h34;
   localparam logic [7:0] OFF_MSC       = 8'h38;
   localparam logic [7:0] OFF_ISTAT     = 8'h3c;
   localparam logic [7:0] OFF_IMASK     = 8'h40;
   // ****************************************
   // Field positions, within the 32-bit word
   // ****************************************
   localparam int ISA_RND_LSB   = 28;
   localparam int PFR0_FW_LSB   = 20;
   localparam int PFR1_TRAP_LSB = 28;
   localparam int HCFG_GF_BIT   = 16;
   localparam int HFA_NS_BIT    = 31;
   localparam int DCS_MIR_LSB   = 29;
   localparam int MDC_EXT_BIT   = 26;
   localparam int MDC_SEL_LSB   = 24;
   localparam int MSC_NS_BIT    = 0;
   localparam int MSC_RANDOM_TRAP_BIT_BIT = 1;
   localparam int EV_FAULT      = 0;
   localparam int EV_TBTRAP     = 1;
   localparam int EV_LORDENY    = 2;
   localparam int EV_W          = 3;
   // ****************************************
   // Values
   // ****************************************
   localparam logic [3:0]  FIELD_ABSENT = 4'h0;
   localparam logic [3:0]  FIELD_V1     = 4'h1;
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;
   typedef enum logic [1:0] {
      W_SECURE = 2'h0,
      W_NONSEC = 2'h1,
      W_REALM  = 2'h2,
      W_ROOT   = 2'h3
   } ssf_world_e;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_RESP = 2'b10
   } ssf_apb_e;
endpackage : ssf_pkg

// >>> verilog/ssf_pol_if.sv
`timescale 1ns/1ns
interface ssf_pol_if import ssf_pkg::*; ();
   ssf_world_e cur_state;
   logic       ext;
   logic [1:0] sel;
   logic       tb_enabled;
   ssf_world_e owner;
   logic       prohibit;
   logic       trap_cond;
   modport core (output cur_state, ext, sel, tb_enabled, input owner, prohibit, trap_cond);
   modport pol  (input cur_state, ext, sel, tb_enabled, output owner, prohibit, trap_cond);
endinterface : ssf_pol_if

// >>> verilog/ssf_top.sv
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module ssf_top import ssf_pkg::*; #(
   parameter bit HAS_RNG      = 1'b0,
   parameter bit HAS_RNG_TRAP = 1'b1,
   parameter bit HAS_FW       = 1'b1
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic [1:0]  cur_state,
   input  wire logic        gf_valid,
   input  wire logic        gf_low_el,
   input  wire logic [62:0] gf_ipa,
   input  wire logic        gf_ns_space,
   input  wire logic [1:0]  ext_dbg_bits,
   input  wire logic        tb_enabled,
   input  wire logic        tb_acc_req,
   input  wire logic        lor_acc_req,
   input  wire logic        lor_hit,
   input  wire logic        lor_pa_ns,
   output logic             route_to_hyp,
   output logic      [1:0]  fault_space,
   output logic             tb_prohibit,
   output logic             tb_trap,
   output logic             lor_access_ok,
   output logic             lor_region_apply
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      ssf_apb_e         apb;
      logic             pready;
      logic [31:0]      prdata;
      logic             pslverr;
      logic             hcfg_gf;
      logic [63:0]      hfa;
      logic [1:0]       hfa_space;
      logic             mdc_ext;
      logic [1:0]       mdc_sel;
      logic             msc_ns;
      logic             msc_random_trap_bit;
      logic [1:0]       dcs_mir;
      logic [EV_W-1:0]  istat;
      logic [EV_W-1:0]  imask;
      logic             irq;
      logic             route;
      logic             tb_prohibit;
      logic             tb_trap;
      logic             lor_ok;
      logic             lor_apply;
   } ssf_regs_s;

   ssf_regs_s st_q;
   ssf_regs_s st_d;
   ssf_pol_if pif ();

   ssf_trace_pol u_pol (
      .pif (pif.pol)
   );

   assign pif.cur_state  = ssf_world_e'(cur_state);
   assign pif.ext        = st_q.mdc_ext;
   assign pif.sel        = st_q.mdc_sel;
   assign pif.tb_enabled = tb_enabled;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] ssf_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : ssf_merge

   function automatic logic [3:0] ssf_rnd_value(input logic random_trap_bit);
      logic [3:0] v;
      v = FIELD_ABSENT;
      if (HAS_RNG || (HAS_RNG_TRAP && random_trap_bit)) begin
         v = FIELD_V1; // RULE_01
      end
      return v;
   endfunction : ssf_rnd_value

   function automatic logic ssf_mapped(input logic [7:0] a);
      return (a <= OFF_IMASK) && (a[1:0] == 2'b00);
   endfunction : ssf_mapped

   // ****************************************
   // Read mux
   // ****************************************
   logic [31:0] rd_word;
   always_comb begin
      rd_word = RST_WORD;
      case (paddr)
         OFF_ISA_HI:  rd_word[ISA_RND_LSB +: 4] = ssf_rnd_value(st_q.msc_random_trap_bit);
         OFF_PFR0_HI: rd_word[PFR0_FW_LSB +: 4] = HAS_FW ? FIELD_V1 : FIELD_ABSENT;        // RULE_03
         OFF_PFR1_LO: rd_word[PFR1_TRAP_LSB +: 4] = HAS_RNG_TRAP ? FIELD_V1 : FIELD_ABSENT; // RULE_04
         OFF_HCFG_HI: rd_word[HCFG_GF_BIT] = st_q.hcfg_gf;
         OFF_HFA_LO:  rd_word = st_q.hfa[31:0];
         OFF_HFA_HI:  rd_word = st_q.hfa[63:32];
         OFF_DCS_LO:  rd_word[DCS_MIR_LSB +: 2] = st_q.dcs_mir;
         OFF_MDC_LO: begin
            rd_word[MDC_EXT_BIT]      = st_q.mdc_ext;
            rd_word[MDC_SEL_LSB +: 2] = st_q.mdc_sel;
         end
         OFF_MSC: begin
            rd_word[MSC_NS_BIT]    = st_q.msc_ns;
            rd_word[MSC_RANDOM_TRAP_BIT_BIT] = st_q.msc_random_trap_bit;
         end
         OFF_ISTAT:   rd_word[EV_W-1:0] = st_q.istat;
         OFF_IMASK:   rd_word[EV_W-1:0] = st_q.imask;
         default:     rd_word = RST_WORD;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   logic            wr_fire;
   logic [31:0]     wd;
   logic [EV_W-1:0] ev;
   logic            fault_route;

   always_comb begin
      st_d        = st_q;
      wr_fire     = st_q.pready && psel && penable && pwrite && !st_q.pslverr;
      wd          = RST_WORD;
      ev          = '0;
      fault_route = gf_valid && gf_low_el && st_q.hcfg_gf; // RULE_05
      // APB: one wait state, answer computed on the first access cycle
      case (st_q.apb)
         APB_IDLE: begin
            st_d.pready = 1'b0;
            if (psel && penable) begin
               st_d.apb     = APB_RESP;
               st_d.pready  = 1'b1;
               st_d.pslverr = !ssf_mapped(paddr);
               st_d.prdata  = (pwrite || !ssf_mapped(paddr)) ? RST_WORD : rd_word;
            end
         end
         APB_RESP: begin
            st_d.apb     = APB_IDLE;
            st_d.pready  = 1'b0;
            st_d.pslverr = 1'b0;
         end
         default: begin
            st_d.apb    = APB_IDLE;
            st_d.pready = 1'b0;
         end
      endcase
      if (wr_fire) begin
         case (paddr)
            OFF_HCFG_HI: begin
               wd           = ssf_merge({15'h0000, st_q.hcfg_gf, 16'h0000}, pwdata, pstrb);
               st_d.hcfg_gf = HAS_FW && wd[HCFG_GF_BIT]; // RULE_06
            end
            OFF_HFA_LO:  st_d.hfa[31:0]  = ssf_merge(st_q.hfa[31:0], pwdata, pstrb);
            OFF_HFA_HI:  st_d.hfa[63:32] = ssf_merge(st_q.hfa[63:32], pwdata, pstrb);
            OFF_MDC_LO: begin
               wd           = ssf_merge({5'h00, st_q.mdc_ext, st_q.mdc_sel, 24'h00_0000}, pwdata, pstrb);
               st_d.mdc_ext = HAS_FW && wd[MDC_EXT_BIT];
               st_d.mdc_sel = wd[MDC_SEL_LSB +: 2];
            end
            OFF_MSC: begin
               wd             = ssf_merge({30'h0000_0000, st_q.msc_random_trap_bit, st_q.msc_ns}, pwdata, pstrb);
               st_d.msc_ns    = wd[MSC_NS_BIT];
               // Trap bit should be set once before lower levels run
               st_d.msc_random_trap_bit = HAS_RNG_TRAP && wd[MSC_RANDOM_TRAP_BIT_BIT]; // RULE_02
            end
            OFF_ISTAT: begin
               wd         = ssf_merge(RST_WORD, pwdata, pstrb);
               st_d.istat = st_q.istat & ~wd[EV_W-1:0];
            end
            OFF_IMASK: begin
               wd         = ssf_merge({29'h0000_0000, st_q.imask}, pwdata, pstrb);
               st_d.imask = wd[EV_W-1:0];
            end
            default: wd = RST_WORD;
         endcase
      end
      // Fault capture wins over a software write in the same cycle
      st_d.route = fault_route;
      if (fault_route) begin
         ev[EV_FAULT]    = 1'b1;
         st_d.hfa[62:0]  = gf_ipa;
         st_d.hfa_space  = cur_state;
         if (ssf_world_e'(cur_state) == W_SECURE) begin
            st_d.hfa[63]   = gf_ns_space; // RULE_07
            st_d.hfa_space = gf_ns_space ? W_NONSEC : W_SECURE;
         end else begin
            // Realm and non-secure targets: bit reads zero, space is the target's own
            st_d.hfa[63] = 1'b0; // RULE_08 RULE_09
         end
      end
      st_d.dcs_mir     = ext_dbg_bits; // RULE_12
      st_d.tb_prohibit = pif.prohibit; // RULE_13
      st_d.tb_trap     = tb_acc_req && pif.trap_cond; // RULE_14
      ev[EV_TBTRAP]    = st_d.tb_trap;
      st_d.lor_ok      = lor_acc_req && st_q.msc_ns; // RULE_10
      ev[EV_LORDENY]   = lor_acc_req && !st_q.msc_ns;
      st_d.lor_apply   = lor_hit && lor_pa_ns; // RULE_11
      // A new event is never lost to a clear in the same cycle
      st_d.istat       = st_d.istat | ev;
      st_d.irq         = |(st_d.istat & st_d.imask);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q     <= '0;
         st_q.apb <= APB_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata           = st_q.prdata;
   assign pready           = st_q.pready;
   assign pslverr          = st_q.pslverr;
   assign irq              = st_q.irq;
   assign route_to_hyp     = st_q.route;
   assign fault_space      = st_q.hfa_space;
   assign tb_prohibit      = st_q.tb_prohibit;
   assign tb_trap          = st_q.tb_trap;
   assign lor_access_ok    = st_q.lor_ok;
   assign lor_region_apply = st_q.lor_apply;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_read_of(logic [7:0] a);
      psel && penable && !pwrite && (st_q.apb == APB_IDLE) && (paddr == a);
   endsequence

   sequence s_routed_fault;
      gf_valid && gf_low_el && st_q.hcfg_gf;
   endsequence

   a_apb_wait_one: assert property (psel && penable && (st_q.apb == APB_IDLE) |=> pready ##1 !pready)
      else $error("APB answer not after exactly one wait state");

   a_rand_field: assert property (s_read_of(OFF_ISA_HI) |=> // RULE_01
      prdata[31:28] == ((HAS_RNG || (HAS_RNG_TRAP && $past(st_q.msc_random_trap_bit))) ? 4'h1 : 4'h0))
      else $error("Random field read value wrong");

   a_fw_field: assert property (s_read_of(OFF_PFR0_HI) |=> prdata[23:20] == (HAS_FW ? 4'h1 : 4'h0)) // RULE_03
      else $error("Four-world field read value wrong");

   a_trap_field: assert property (s_read_of(OFF_PFR1_LO) |=> // RULE_04
      prdata[31:28] == (HAS_RNG_TRAP ? 4'h1 : 4'h0))
      else $error("Trap support field read value wrong");

   a_fault_route: assert property (s_routed_fault |=> route_to_hyp && (st_q.hfa[62:0] == $past(gf_ipa))) // RULE_05
      else $error("Granule fault not routed or not captured");

   a_no_route_clr: assert property (!(gf_valid && gf_low_el && st_q.hcfg_gf) |=> !route_to_hyp) // RULE_05
      else $error("Route without enable");

   a_route_res0: assert property (!HAS_FW |-> !st_q.hcfg_gf) // RULE_06
      else $error("Route bit set without four-world support");

   a_space_zero: assert property (s_routed_fault ##0 (cur_state != 2'h0) |=> !st_q.hfa[63] // RULE_08 RULE_09
      && (fault_space == $past(cur_state)))
      else $error("Space bit not zero for hypervisor-level target");

   a_lor_access: assert property (lor_acc_req |=> lor_access_ok == $past(st_q.msc_ns)) // RULE_10
      else $error("Ordering-region access gate wrong");

   a_lor_space: assert property (##1 lor_region_apply |-> $past(lor_pa_ns) && $past(lor_hit)) // RULE_11
      else $error("Ordering region applied outside non-secure space");

   a_dbg_mirror: assert property (##1 st_q.dcs_mir == $past(ext_dbg_bits)) // RULE_12
      else $error("Debug status mirror stale");

   a_tb_prohibit: assert property (tb_enabled && st_q.mdc_ext && st_q.mdc_sel[1] && (cur_state == 2'h2) // RULE_13
      |=> !tb_prohibit)
      else $error("Realm owner prohibited from tracing");

   a_tb_trap_all: assert property (tb_acc_req && !st_q.mdc_sel[0] |=> tb_trap) // RULE_14
      else $error("Trap missed with low select bit zero");

   a_irq_level: assert property (##1 irq == |(st_q.istat & st_q.imask))
      else $error("Interrupt level disagrees with status and mask");

   a_apb_err_map: assert property (psel && penable && (st_q.apb == APB_IDLE)
      && ((paddr > OFF_IMASK) || (paddr[1:0] != 2'b00)) |=> pready && pslverr)
      else $error("Unmapped access not refused");

   a_apb_err_quiet: assert property (!pready |-> !pslverr)
      else $error("Error flag outside a transfer answer");

   a_space_secure: assert property (s_routed_fault ##0 (cur_state == 2'h0) |=> // RULE_07
      (st_q.hfa[63] == $past(gf_ns_space)) && (fault_space == {1'b0, $past(gf_ns_space)}))
      else $error("Secure target address space not captured");

   a_fault_sticky: assert property (s_routed_fault |=> st_q.istat[EV_FAULT]) // RULE_05
      else $error("Routed fault did not set its status bit");

   a_lor_deny_evt: assert property (lor_acc_req && !st_q.msc_ns |=> st_q.istat[EV_LORDENY]) // RULE_10
      else $error("Denied ordering-region access not flagged");

   a_lor_idle: assert property (!lor_acc_req |=> !lor_access_ok) // RULE_10
      else $error("Ordering-region grant without a request");

   a_tb_prohibit_off: assert property (!tb_enabled |=> !tb_prohibit) // RULE_13
      else $error("Tracing prohibited with the buffer disabled");

   a_tb_secure_own: assert property (tb_enabled && !st_q.mdc_ext && !st_q.mdc_sel[1] // RULE_13
      && (cur_state != 2'h0) |=> tb_prohibit)
      else $error("Non-owner allowed to trace under secure ownership");

   a_tb_reserved: assert property (tb_enabled && st_q.mdc_ext && !st_q.mdc_sel[1] // RULE_15
      && (cur_state == 2'h0) |=> !tb_prohibit)
      else $error("Reserved owner code not treated as secure");

   a_tb_trap_owner: assert property (tb_acc_req && (st_q.mdc_sel == 2'b11) && !st_q.mdc_ext // RULE_14
      && (cur_state == 2'h1) |=> !tb_trap)
      else $error("Owning state trapped with low select bit one");

   a_tb_trap_idle: assert property (!tb_acc_req |=> !tb_trap) // RULE_14
      else $error("Trace-buffer trap without an access");

   a_mdc_write: assert property (wr_fire && (paddr == OFF_MDC_LO) && pstrb[3] |=> // RULE_13
      (st_q.mdc_sel == $past(pwdata[MDC_SEL_LSB +: 2]))
      && (st_q.mdc_ext == (HAS_FW && $past(pwdata[MDC_EXT_BIT]))))
      else $error("Trace owner select write lost");
endmodule : ssf_top

// >>> verilog/ssf_trace_pol.sv
`timescale 1ns/1ns
module ssf_trace_pol import ssf_pkg::*; (
   ssf_pol_if.pol pif
);
   // ****************************************
   // Trace owner decode
   // ****************************************
   // Reserved ext=1, select 0x falls back to secure ownership
   always_comb begin
      if (pif.ext && pif.sel[1]) begin
         pif.owner = W_REALM; // RULE_13
      end else if (pif.sel[1]) begin
         pif.owner = W_NONSEC; // RULE_13
      end else begin
         pif.owner = W_SECURE; // RULE_15
      end
   end
   // Root never owns the buffer, so it is always a non-owner here
   assign pif.prohibit  = pif.tb_enabled && (pif.cur_state != pif.owner); // RULE_13
   assign pif.trap_cond = !pif.sel[0] || (pif.cur_state != pif.owner);    // RULE_14
endmodule : ssf_trace_pol
